// ==== subtract_swap_alu.sv ====
// subtract/nibble-swap execution datapath with an AXI4-Lite register slave
//
// Notes on behaviour
// - literal minus accumulator goes to accumulator, updating N, OV, C, DC, Z.
// - file register minus accumulator, two's complement, updating all five flags.
// - with-borrow form also subtracts inverted carry; cleared carry means borrow.
// - nibble exchange swaps the halves of the file value; flags untouched.
// - destination bit 0 writes accumulator, 1 writes back the file register.
// - access bit 0 resolves the file address inside the access bank.
// - access bit 1 prefixes the file address with the bank select register.
// - access 0, extended set on, address up to 95: indexed literal offset.
// - one word, one cycle of four phases: decode, read, process, write.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module subtract_swap_alu (
   // clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // write address channel
   input  wire logic [alu_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   // write data channel
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   // write response channel
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   // read address channel
   input  wire logic [alu_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   // read data channel
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready
);
   import alu_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   typedef struct packed {
      phase_t                         phase;
      op_t                            op;
      logic [15:0]                    instr;
      logic [11:0]                    addr;
      logic [7:0]                     opnd;
      logic [7:0]                     res;
      logic [4:0]                     flg_new;
      logic [7:0]                     accum;
      logic [4:0]                     flags;
      logic [3:0]                     bank_select_register;
      logic                           ext_en;
      logic [11:0]                    idx_base;
      logic [MEM_IDX_W-1:0]           mem_ptr;
      logic                           illegal;
      logic [MEM_DEPTH-1:0][7:0]      mem;
      logic                           aw_have;
      logic [ADDR_W-1:0]              wr_addr;
      logic                           w_have;
      logic [31:0]                    wr_data;
      logic [3:0]                     wr_strb;
      logic                           awready;
      logic                           wready;
      logic                           bvalid;
      logic [1:0]                     bresp;
      logic                           arready;
      logic                           rvalid;
      logic [31:0]                    rdata;
      logic [1:0]                     rresp;
   } state_t;

   state_t      st_q;
   state_t      st_d;
   logic [7:0]  diff;
   logic        c_out;
   logic        dc_out;
   logic        ov_out;
   logic        cin;
   assign cin = (st_q.op == OP_SUBB) ? st_q.flags[FLG_C] : 1'b1;
   sub8 u_sub (
      .minuend     (st_q.opnd),
      .subtrahend  (st_q.accum),
      .carry_in    (cin),
      .diff        (diff),
      .carry       (c_out),
      .half_carry  (dc_out),
      .signed_wrap (ov_out)
   );
   always_comb begin
      logic        busy;
      logic [31:0] m;
      logic        hit;
      busy = (st_q.phase != PH_IDLE);
      m    = 32'h0000_0000;
      hit  = 1'b0;
      st_d = st_q;

      // instruction phases
      case (st_q.phase)
         PH_IDLE: st_d.phase = PH_IDLE;
         PH_DECODE: begin
            st_d.op    = decode_op(st_q.instr);
            st_d.addr  = resolve_addr(st_q.instr, st_q.bank_select_register, st_q.ext_en,
                                      st_q.idx_base);
            st_d.phase = PH_READ;
         end
         PH_READ: begin
            st_d.opnd  = (st_q.op == OP_LIT) ? st_q.instr[7:0]
                                             : st_q.mem[st_q.addr[MEM_IDX_W-1:0]];
            st_d.phase = PH_PROC;
         end
         PH_PROC: begin
            if (st_q.op == OP_SWAP)
               st_d.res = swap_nib(st_q.opnd);
            else
               st_d.res = diff;
            st_d.flg_new[FLG_C]  = c_out;
            st_d.flg_new[FLG_DC] = dc_out;
            st_d.flg_new[FLG_Z]  = (diff == 8'h00);
            st_d.flg_new[FLG_OV] = ov_out;
            st_d.flg_new[FLG_N]  = diff[7];
            st_d.phase = PH_WRITE;
         end
         PH_WRITE: begin
            st_d.illegal = (st_q.op == OP_NONE);
            if (st_q.op == OP_LIT || (st_q.op != OP_NONE && !st_q.instr[DEST_BIT]))
               st_d.accum = st_q.res;
            else if (st_q.op != OP_NONE)
               st_d.mem[st_q.addr[MEM_IDX_W-1:0]] = st_q.res;
            // swap leaves flags alone
            if (st_q.op != OP_NONE && st_q.op != OP_SWAP)
               st_d.flags = st_q.flg_new;
            st_d.phase = PH_IDLE;
         end
         default: st_d.phase = PH_IDLE;
      endcase

      // write channels: address and data taken in either order
      if (awvalid && st_q.awready) begin
         st_d.aw_have = 1'b1;
         st_d.wr_addr = awaddr;
      end
      if (wvalid && st_q.wready) begin
         st_d.w_have  = 1'b1;
         st_d.wr_data = wdata;
         st_d.wr_strb = wstrb;
      end
      if (st_q.bvalid && bready)
         st_d.bvalid = 1'b0;
      if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
         hit = 1'b1;
         // core owns its state while an instruction is in flight
         case (st_q.wr_addr)
            OFS_INSTR: begin
               m = merge({16'h0000, st_q.instr}, st_q.wr_data, st_q.wr_strb);
               if (!busy) begin
                  st_d.instr = m[15:0];
                  st_d.phase = PH_DECODE;
               end
            end
            OFS_ACCUM: begin
               m = merge({24'h000000, st_q.accum}, st_q.wr_data, st_q.wr_strb);
               if (!busy)
                  st_d.accum = m[7:0];
            end
            OFS_STATUS: begin
               m = merge({27'h0000000, st_q.flags}, st_q.wr_data, st_q.wr_strb);
               if (!busy)
                  st_d.flags = m[4:0];
            end
            OFS_BANK: begin
               m = merge({28'h0000000, st_q.bank_select_register}, st_q.wr_data, st_q.wr_strb);
               if (!busy)
                  st_d.bank_select_register = m[3:0];
            end
            OFS_CONFIG: begin
               m = merge({31'h00000000, st_q.ext_en}, st_q.wr_data, st_q.wr_strb);
               if (!busy)
                  st_d.ext_en = m[CFG_EXT_EN];
            end
            OFS_IDX_BASE: begin
               m = merge({20'h00000, st_q.idx_base}, st_q.wr_data, st_q.wr_strb);
               if (!busy)
                  st_d.idx_base = m[11:0];
            end
            OFS_MEM_PTR: begin
               m = merge({26'h0000000, st_q.mem_ptr}, st_q.wr_data, st_q.wr_strb);
               st_d.mem_ptr = m[MEM_IDX_W-1:0];
            end
            OFS_MEM_DATA: begin
               m = merge({24'h000000, st_q.mem[st_q.mem_ptr]}, st_q.wr_data, st_q.wr_strb);
               if (!busy)
                  st_d.mem[st_q.mem_ptr] = m[7:0];
            end
            OFS_RES_ADDR: hit = 1'b1;
            default: hit = 1'b0;
         endcase
         st_d.aw_have = 1'b0;
         st_d.w_have  = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = hit ? RESP_OKAY : RESP_SLVERR;
      end
      st_d.awready = !st_d.aw_have;
      st_d.wready  = !st_d.w_have;

      // read channel: answer registered at the address handshake edge
      if (st_q.rvalid && rready)
         st_d.rvalid = 1'b0;
      if (arvalid && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rresp  = RESP_OKAY;
         case (araddr)
            OFS_INSTR:    st_d.rdata = {16'h0000, st_q.instr};
            OFS_ACCUM:    st_d.rdata = {24'h000000, st_q.accum};
            OFS_STATUS:   st_d.rdata = {22'h000000, st_q.illegal, busy, 3'h0, st_q.flags};
            OFS_BANK:     st_d.rdata = {28'h0000000, st_q.bank_select_register};
            OFS_CONFIG:   st_d.rdata = {31'h00000000, st_q.ext_en};
            OFS_IDX_BASE: st_d.rdata = {20'h00000, st_q.idx_base};
            OFS_MEM_PTR:  st_d.rdata = {26'h0000000, st_q.mem_ptr};
            OFS_MEM_DATA: st_d.rdata = {24'h000000, st_q.mem[st_q.mem_ptr]};
            OFS_RES_ADDR: st_d.rdata = {20'h00000, st_q.addr};
            default: begin
               st_d.rdata = 32'h0000_0000;
               st_d.rresp = RESP_SLVERR;
            end
         endcase
      end
      st_d.arready = !st_d.rvalid;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q       <= '0;
         st_q.accum <= RST_ACCUM;
         st_q.flags <= RST_FLAGS;
      end else begin
         st_q <= st_d;
      end
   end
   assign awready = st_q.awready;
   assign wready  = st_q.wready;
   assign bvalid  = st_q.bvalid;
   assign bresp   = st_q.bresp;
   assign arready = st_q.arready;
   assign rvalid  = st_q.rvalid;
   assign rdata   = st_q.rdata;
   assign rresp   = st_q.rresp;
   // checks
   logic wr_q4;
   logic to_file;
   assign wr_q4   = (st_q.phase == PH_WRITE);
   assign to_file = st_q.instr[DEST_BIT] && st_q.op != OP_LIT && st_q.op != OP_NONE;

   sequence s_tail;
      st_q.phase == PH_READ ##1 st_q.phase == PH_PROC ##1
      st_q.phase == PH_WRITE ##1 st_q.phase == PH_IDLE;
   endsequence

   phase_order_a: assert property (st_q.phase == PH_DECODE |=> s_tail)
      else $error("instruction phases out of order");
   lit_result_a: assert property (wr_q4 && st_q.op == OP_LIT |=>
         st_q.accum == 8'($past(st_q.instr[7:0]) - $past(st_q.accum)))
      else $error("literal minus accumulator wrong");
   sub_result_a: assert property (wr_q4 && st_q.op == OP_SUB && to_file |=>
         st_q.mem[$past(st_q.addr[MEM_IDX_W-1:0])] == 8'($past(st_q.opnd) - $past(st_q.accum)))
      else $error("file minus accumulator wrong");
   borrow_result_a: assert property (st_q.phase == PH_PROC && st_q.op == OP_SUBB |=>
         st_q.res == 8'(st_q.opnd - st_q.accum - {7'h00, !st_q.flags[FLG_C]}))
      else $error("subtract with borrow wrong");
   swap_flags_a: assert property (wr_q4 && st_q.op == OP_SWAP |=>
         $stable(st_q.flags) && st_q.res == {$past(st_q.opnd[3:0]), $past(st_q.opnd[7:4])})
      else $error("swap changed flags or result");
   dest_accum_a: assert property (wr_q4 && st_q.op inside {OP_SUB, OP_SUBB, OP_SWAP} &&
         !st_q.instr[DEST_BIT] |=> st_q.accum == $past(st_q.res) && $stable(st_q.mem))
      else $error("destination select wrong");
   access_bank_a: assert property (st_q.phase == PH_READ && !st_q.instr[ACC_BIT] &&
         !(st_q.ext_en && st_q.instr[7:0] <= INDEXED_MAX) |->
         st_q.addr[7:0] == st_q.instr[7:0] &&
         st_q.addr[11:8] == (st_q.instr[7:0] <= INDEXED_MAX ? ACC_LOW_BANK : ACC_HIGH_BANK))
      else $error("access bank address wrong");
   bank_sel_a: assert property (st_q.phase == PH_READ && st_q.instr[ACC_BIT] |->
         st_q.addr == {st_q.bank_select_register, st_q.instr[7:0]})
      else $error("banked address wrong");
   indexed_addr_a: assert property (st_q.phase == PH_READ && !st_q.instr[ACC_BIT] &&
         st_q.ext_en && st_q.instr[7:0] <= INDEXED_MAX |->
         st_q.addr == 12'(st_q.idx_base + {4'h0, st_q.instr[7:0]}))
      else $error("indexed literal offset address wrong");
   // a pending borrow needs one more in the minuend to keep carry set
   flag_set_a: assert property (wr_q4 && st_q.op inside {OP_LIT, OP_SUB, OP_SUBB} |=>
         st_q.flags[FLG_Z] == ($past(st_q.res) == 8'h00) &&
         st_q.flags[FLG_N] == $past(st_q.res[7]) &&
         st_q.flags[FLG_C] == ({1'b0, $past(st_q.opnd)} >= {1'b0, $past(st_q.accum)} +
                               {8'h00, $past(st_q.op == OP_SUBB && !st_q.flags[FLG_C])}))
      else $error("zero, negative or carry flag wrong");
endmodule

// ==== alu_pkg.sv ====
// constants, types and helper functions for the subtract/swap datapath
package alu_pkg;
   localparam int             ADDR_W        = 6;
   localparam int             MEM_DEPTH     = 64;
   localparam int             MEM_IDX_W     = 6;
   // register byte offsets
   localparam logic [5:0]     OFS_INSTR     = 6'h00;
   localparam logic [5:0]     OFS_ACCUM     = 6'h04;
   localparam logic [5:0]     OFS_STATUS    = 6'h08;
   localparam logic [5:0]     OFS_BANK      = 6'h0C;
   localparam logic [5:0]     OFS_CONFIG    = 6'h10;
   localparam logic [5:0]     OFS_IDX_BASE  = 6'h14;
   localparam logic [5:0]     OFS_MEM_PTR   = 6'h18;
   localparam logic [5:0]     OFS_MEM_DATA  = 6'h1C;
   localparam logic [5:0]     OFS_RES_ADDR  = 6'h20;
   // status and config fields
   localparam int             FLG_C         = 0;
   localparam int             FLG_DC        = 1;
   localparam int             FLG_Z         = 2;
   localparam int             FLG_OV        = 3;
   localparam int             FLG_N         = 4;
   localparam int             STAT_BUSY     = 8;
   localparam int             STAT_ILLEGAL  = 9;
   localparam int             CFG_EXT_EN    = 0;
   // instruction fields
   localparam int             DEST_BIT      = 9;
   localparam int             ACC_BIT       = 8;
   localparam logic [7:0]     OPC_LIT       = 8'h08;
   localparam logic [5:0]     OPC_SUB       = 6'h17;
   localparam logic [5:0]     OPC_SUBB      = 6'h16;
   localparam logic [5:0]     OPC_SWAP      = 6'h0E;
   localparam logic [7:0]     INDEXED_MAX   = 8'h5F;
   localparam logic [3:0]     ACC_LOW_BANK  = 4'h0;
   localparam logic [3:0]     ACC_HIGH_BANK = 4'hF;
   // reset values and bus response codes
   localparam logic [7:0]     RST_ACCUM     = 8'h00;
   localparam logic [4:0]     RST_FLAGS     = 5'h00;
   localparam logic [1:0]     RESP_OKAY     = 2'h0;
   localparam logic [1:0]     RESP_SLVERR   = 2'h2;

   typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROC, PH_WRITE} phase_t;
   typedef enum logic [2:0] {OP_NONE, OP_LIT, OP_SUB, OP_SUBB, OP_SWAP} op_t;

   function automatic op_t decode_op(input logic [15:0] instr);
      if (instr[15:8] == OPC_LIT)
         return OP_LIT;
      else if (instr[15:10] == OPC_SUB)
         return OP_SUB;
      else if (instr[15:10] == OPC_SUBB)
         return OP_SUBB;
      else if (instr[15:10] == OPC_SWAP)
         return OP_SWAP;
      else
         return OP_NONE;
   endfunction

   // 12-bit data address of a file operand
   function automatic logic [11:0] resolve_addr(input logic [15:0] instr, input logic [3:0] bank_select_register,
                                                input logic ext_en, input logic [11:0] base);
      logic [7:0] f;
      f = instr[7:0];
      if (instr[ACC_BIT])
         return {bank_select_register, f};
      else if (ext_en && f <= INDEXED_MAX)
         return base + {4'h0, f};
      else if (f <= INDEXED_MAX)
         return {ACC_LOW_BANK, f};
      else
         return {ACC_HIGH_BANK, f};
   endfunction

   function automatic logic [7:0] swap_nib(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i])
            r[i*8 +: 8] = wd[i*8 +: 8];
      end
      return r;
   endfunction
endpackage

// ==== sub8.sv ====
// 8-bit subtractor: minuend - subtrahend - not(carry_in), with borrow-style flags
`timescale 1ns/1ps
module sub8 (
   // operands
   input  wire logic [7:0] minuend,
   input  wire logic [7:0] subtrahend,
   input  wire logic       carry_in,
   // results
   output logic      [7:0] diff,
   output logic            carry,
   output logic            half_carry,
   output logic            signed_wrap
);
   logic [8:0] full;
   logic [4:0] low;

   // carry set means no borrow, so add the complement plus carry
   assign full        = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
   assign low         = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
   assign diff        = full[7:0];
   assign carry       = full[8];
   assign half_carry  = low[4];
   assign signed_wrap = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]);
endmodule

// ==== tb_subtract_swap_alu.sv ====
// self-checking bench for the subtract/swap datapath, driven over its register bus
`timescale 1ns/1ps
module tb_subtract_swap_alu;
   import alu_pkg::*;
   typedef struct {logic w; logic [5:0] a; logic [31:0] d; logic [1:0] r;} note_t;
   logic        aclk, aresetn;
   logic [5:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, seed, x;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        ill;
   note_t       notes[$];
   int          err_count, checks_done;

   subtract_swap_alu subtract_swap_alu_i (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   function automatic logic [31:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic bad(input string what, input logic [31:0] e, input logic [31:0] s);
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
   endtask

   task automatic finish_test();
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // responses are matched in issue order; only one transfer is ever outstanding
   always @(posedge aclk) begin
      note_t n;
      if (aresetn === 1'b1 && ((rvalid === 1'b1 && rready === 1'b1) ||
                               (bvalid === 1'b1 && bready === 1'b1))) begin
         checks_done++;
         if (notes.size() == 0) begin
            bad("unexpected response", 32'h0, rdata);
         end else begin
            n = notes.pop_front();
            if (n.w) begin
               if (bvalid !== 1'b1 || bresp !== n.r)
                  bad($sformatf("bresp@%h", n.a), {30'h0, n.r}, {30'h0, bresp});
            end else begin
               if (rvalid !== 1'b1 || rdata !== n.d)
                  bad($sformatf("rdata@%h", n.a), n.d, rdata);
               if (rresp !== n.r)
                  bad($sformatf("rresp@%h", n.a), {30'h0, n.r}, {30'h0, rresp});
            end
         end
      end
   end

   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      n = 0;
      notes.push_back('{1'b1, a, 32'h0, er});
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      bready <= 1'b0;
      if (n >= 100)
         bad("bvalid wait", 32'h1, 32'h0);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      n = 0;
      notes.push_back('{1'b0, a, d, er});
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      rready <= 1'b0;
      if (n >= 100)
         bad("rvalid wait", 32'h1, 32'h0);
   endtask

   // kind: 0 literal, 1 plain subtract, 2 with borrow, 3 nibble exchange
   task automatic trial(input int kind, input logic [7:0] opv, input logic [7:0] av,
                        input logic [4:0] fv, input logic dd, input logic aa,
                        input logic [7:0] f, input logic poke);
      logic [3:0]  bank;
      logic        ext, cin;
      logic [11:0] base, ra;
      logic [15:0] ins;
      logic [7:0]  r, acc, memv;
      logic [8:0]  t;
      logic [4:0]  h, flg;
      logic [31:0] v;
      v = nxt();
      bank = v[3:0];
      ext  = v[4];
      base = v[27:16];
      if (aa)
         ra = {bank, f};
      else if (ext && f <= 8'h5F)
         ra = base + {4'h0, f};
      else
         ra = {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
      wr(OFS_ACCUM, {24'h0, av});
      wr(OFS_STATUS, {27'h0, fv});
      wr(OFS_BANK, {28'h0, bank});
      wr(OFS_CONFIG, {31'h0, ext});
      wr(OFS_IDX_BASE, {20'h0, base});
      wr(OFS_MEM_PTR, {26'h0, ra[5:0]});
      wr(OFS_MEM_DATA, {24'h0, opv});
      case (kind)
         0: ins = {OPC_LIT, opv};
         1: ins = {OPC_SUB, dd, aa, f};
         2: ins = {OPC_SUBB, dd, aa, f};
         default: ins = {OPC_SWAP, dd, aa, f};
      endcase
      cin = (kind == 2) ? fv[0] : 1'b1;
      t = {1'b0, opv} + {1'b0, ~av} + {8'h0, cin};
      h = {1'b0, opv[3:0]} + {1'b0, ~av[3:0]} + {4'h0, cin};
      r = (kind == 3) ? {opv[3:0], opv[7:4]} : t[7:0];
      flg = fv;
      if (kind != 3)
         flg = {r[7], (opv[7] != av[7]) && (r[7] != opv[7]), r == 8'h00, h[4], t[8]};
      acc  = (kind == 0 || !dd) ? r : av;
      memv = (kind != 0 && dd) ? r : opv;
      wr(OFS_INSTR, {16'h0, ins});
      // lands in the last busy cycle, so it must be dropped
      if (poke)
         wr(OFS_ACCUM, 32'h0000_00AA);
      repeat (6) @(posedge aclk);
      rd(OFS_ACCUM, {24'h0, acc});
      rd(OFS_STATUS, {22'h0, ill, 4'h0, flg});
      if (kind != 0) begin
         rd(OFS_RES_ADDR, {20'h0, ra});
         rd(OFS_MEM_DATA, {24'h0, memv});
      end
   endtask

   initial begin
      aresetn = 1'b0;
      awaddr = 6'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
      bready = 1'b0; araddr = 6'h00; arvalid = 1'b0; rready = 1'b0;
      seed = 32'h9E45487A;
      ill = 1'b0;
      err_count = 0;
      checks_done = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i <= 8; i++)
         rd(6'(i * 4), 32'h0);
      rd(6'h24, 32'h0, RESP_SLVERR);
      wr(6'h24, 32'h1, RESP_SLVERR);
      trial(0, 8'h02, 8'h01, 5'h00, 1'b0, 1'b0, 8'h00, 1'b0);
      trial(0, 8'h02, 8'h02, 5'h00, 1'b0, 1'b0, 8'h00, 1'b1);
      trial(0, 8'h02, 8'h03, 5'h00, 1'b0, 1'b0, 8'h00, 1'b0);
      trial(1, 8'h03, 8'h02, 5'h00, 1'b1, 1'b0, 8'h20, 1'b0);
      trial(1, 8'h01, 8'h02, 5'h1F, 1'b0, 1'b1, 8'hA0, 1'b1);
      trial(2, 8'h19, 8'h0D, 5'h01, 1'b1, 1'b0, 8'h60, 1'b0);
      trial(2, 8'h1B, 8'h1A, 5'h00, 1'b0, 1'b0, 8'h5F, 1'b0);
      trial(2, 8'h03, 8'h0E, 5'h01, 1'b1, 1'b1, 8'h05, 1'b0);
      trial(3, 8'h53, 8'h77, 5'h15, 1'b1, 1'b0, 8'h10, 1'b0);
      trial(3, 8'hC4, 8'h11, 5'h0A, 1'b0, 1'b1, 8'hF3, 1'b1);
      for (int i = 0; i < 48; i++) begin
         x = nxt();
         trial(int'(x[1:0]), x[15:8], x[23:16], x[28:24], x[2], x[3],
            x[31:24], x[29]);
      end
      // unknown opcode: accumulator and flags hold, the illegal marker sets
      wr(OFS_ACCUM, 32'h0000_005A);
      wr(OFS_STATUS, 32'h0000_0015);
      rd(OFS_STATUS, {22'h0, 1'b0, 4'h0, 5'h15});
      wr(OFS_INSTR, 32'h0000_FFFF);
      repeat (6) @(posedge aclk);
      ill = 1'b1;
      rd(OFS_STATUS, {22'h0, 1'b1, 4'h0, 5'h15});
      rd(OFS_ACCUM, 32'h0000_005A);
      repeat (3) @(posedge aclk);
      finish_test();
   end

   initial begin
      repeat (40000) @(posedge aclk);
      err_count++;
      finish_test();
   end
endmodule
